// >>> logic/dusc_pkg.sv
// Purpose: constants and types shared by the unlock/seek/sense command block
// Assumes: apb register map, 32-bit words, one register per aligned word
// Notes: offsets are byte addresses
package dusc_pkg;
   localparam logic [7:0] DUSC_OP_UNLOCK = 8'hf2;
   localparam logic [3:0] DUSC_OP_SEEK_HI = 4'h7;
   localparam logic [7:0] DUSC_OP_SENSE = 8'hf0;
   localparam logic [7:0] DUSC_SENSE_FEATURE = 8'h01;
   localparam logic [2:0] DUSC_ATTEMPTS_INIT = 3'h5;
   localparam int DUSC_PW_WORDS = 16;
   localparam int DUSC_SECTOR_WORDS = 256;
   // register byte offsets
   localparam logic [7:0] DUSC_A_FEATURE = 8'h00;
   localparam logic [7:0] DUSC_A_COUNT = 8'h04;
   localparam logic [7:0] DUSC_A_SECNUM = 8'h08;
   localparam logic [7:0] DUSC_A_CYL_LO = 8'h0c;
   localparam logic [7:0] DUSC_A_CYL_HI = 8'h10;
   localparam logic [7:0] DUSC_A_HEAD = 8'h14;
   localparam logic [7:0] DUSC_A_CMD = 8'h18;
   localparam logic [7:0] DUSC_A_ERROR = 8'h1c;
   localparam logic [7:0] DUSC_A_DATA = 8'h20;
   localparam logic [7:0] DUSC_A_SECURITY = 8'h24;
   localparam logic [7:0] DUSC_A_POS = 8'h28;
   // field positions
   localparam int DUSC_ST_ERR = 0;
   localparam int DUSC_ST_DRQ = 3;
   localparam int DUSC_ST_DSC = 4;
   localparam int DUSC_ST_RDY = 6;
   localparam int DUSC_ST_BSY = 7;
   localparam int DUSC_ER_ABT = 2;
   localparam int DUSC_ER_IDN = 4;
   localparam int DUSC_HD_LBA = 6;
   // security register bits
   localparam int DUSC_SEC_EN = 0;
   localparam int DUSC_SEC_MAX = 1;
   localparam int DUSC_SEC_LOCKED = 2;
   localparam logic [7:0] DUSC_HEAD_RESET = 8'ha0;
   localparam logic [7:0] DUSC_TEMP_SAT_LO = 8'h00;
   localparam logic [7:0] DUSC_TEMP_SAT_HI = 8'hff;
   typedef enum logic [2:0] {
      DUSC_IDLE = 3'b000,
      DUSC_XFER = 3'b001,
      DUSC_CHECK = 3'b011,
      DUSC_SEEK = 3'b010,
      DUSC_DONE = 3'b110
   } dusc_state_t;
endpackage : dusc_pkg

// >>> logic/dusc_cmp_if.sv
// Purpose: carries one password word comparison between top and comparer
// Assumes: single clock
// Notes: none
`timescale 1ns/1ps
`default_nettype none
interface dusc_cmp_if;
   logic clear;
   logic load;
   logic [31:0] got;
   logic [31:0] want;
   logic match;
   modport top (output clear, output load, output got, output want,
      input match);
   modport cmp (input clear, input load, input got, input want,
      output match);
endinterface : dusc_cmp_if
`default_nettype wire

// >>> logic/dusc_pw_cmp.sv
// Purpose: accumulates equality of password words over one sector
// Assumes: clear before the first word of a sector
// Notes: all 64 bytes always significant
`timescale 1ns/1ps
`default_nettype none
module dusc_pw_cmp (
   input wire logic pclk,
   input wire logic presetn,
   dusc_cmp_if.cmp c
);
   logic same;
   wire word_eq = (c.got == c.want);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         same <= 1'b1;
      end else if (c.clear) begin
         same <= 1'b1;
      end else if (c.load) begin
         same <= same & word_eq;
      end
   end
   assign c.match = same;
endmodule : dusc_pw_cmp
`default_nettype wire

// >>> logic/dusc_top.sv
// Purpose: unlock, seek and sense-condition command handler behind apb
// Assumes: host loads parameter registers before the command write
// Notes: stored passwords and temperature are inputs; security level is a register
// Operation
// - opcode f2 decodes as unlock
// - unlock clears lock; reset relocks
// - unlock takes exactly one data sector
// - word0 bit0 identifier; words 1-16 password
// - master at high level compares master
// - master at maximum level always rejected
// - user identifier compares user password
// - mismatch aborts, decrements counter from five
// - zero counter rejects unlock before the data phase
// - security disabled with user aborts
// - post-data abort for mismatch, level or identifier refusal
// - opcodes 7x decode as seek
// - seek positions track, selects head
// - seek needs no formatted media
// - lba target from sector, cylinders, head
// - chs target from cylinders and head
// - lba seek reports position back
// - opcode f0 returns result in count
// - sense needs feature 01, else abort
// - temperature code half minus twenty, saturated
`timescale 1ns/1ps
`default_nettype none
module dusc_top
   import dusc_pkg::*;
#(
   parameter int SEEK_CYCLES = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [32*DUSC_PW_WORDS-1:0] master_password,
   input wire logic [32*DUSC_PW_WORDS-1:0] user_password,
   input wire logic [7:0] temperature_deg,
   input wire logic temperature_negative,
   output logic [27:0] seek_target,
   output logic seek_lba,
   output logic seek_start
);
   dusc_state_t state, next_state;
   logic [7:0] feature, count, secnum, cyl_lo, cyl_hi, head, cmd;
   logic [7:0] error_flags;
   logic busy, drq, err, dsc;
   logic locked, sec_en, sec_max;
   logic [2:0] attempts;
   logic [7:0] word_idx;
   logic ident_master;
   logic [7:0] seek_cnt;
   logic [7:0] temp_code;

   dusc_cmp_if cmp_bus ();
   dusc_pw_cmp u_cmp (
      .pclk(pclk),
      .presetn(presetn),
      .c(cmp_bus.cmp)
   );

   wire wr = psel & penable & pwrite;
   wire rd_unused = psel & penable & ~pwrite;

   // one select per register; reads and writes share the decode
   wire sel_feature = (paddr == DUSC_A_FEATURE);
   wire sel_count = (paddr == DUSC_A_COUNT);
   wire sel_secnum = (paddr == DUSC_A_SECNUM);
   wire sel_cyl_lo = (paddr == DUSC_A_CYL_LO);
   wire sel_cyl_hi = (paddr == DUSC_A_CYL_HI);
   wire sel_head = (paddr == DUSC_A_HEAD);
   wire sel_cmd = (paddr == DUSC_A_CMD);
   wire sel_error = (paddr == DUSC_A_ERROR);
   wire sel_data = (paddr == DUSC_A_DATA);
   wire sel_security = (paddr == DUSC_A_SECURITY);
   wire sel_pos = (paddr == DUSC_A_POS);
   wire wr_cmd = wr & sel_cmd & ~busy;
   wire wr_data = wr & sel_data & drq;
   wire wr_param = wr & ~busy;
   wire [7:0] op = pwdata[7:0];
   wire is_unlock = (op == DUSC_OP_UNLOCK);
   wire is_seek = (op[7:4] == DUSC_OP_SEEK_HI);
   wire is_sense = (op == DUSC_OP_SENSE);
   wire lba_mode = head[DUSC_HD_LBA];
   // password words sit at 1..16 of the sector
   wire in_pw = (word_idx >= 8'd1) && (word_idx <= 8'(DUSC_PW_WORDS));
   wire [3:0] pw_sel = 4'(word_idx - 8'd1);
   wire last_word = (word_idx == 8'(DUSC_SECTOR_WORDS - 1));
   wire [31:0] want_master = master_password[32*pw_sel +: 32];
   wire [31:0] want_user = user_password[32*pw_sel +: 32];
   // early refusals happen before the data phase
   wire pre_abort = (attempts == 3'h0);
   // level and identifier refusals are decided after the sector arrives
   wire reject_level = ident_master & sec_max;
   wire reject_off = ~ident_master & ~sec_en;
   wire pw_bad = ~cmp_bus.match;
   wire seek_done = (seek_cnt == 8'(SEEK_CYCLES - 1));

   // level and identifier refusals are judged only once the whole sector is in
   wire refuse_late = reject_level | reject_off;
   wire check_cycle = (state == DUSC_CHECK);
   wire seek_end = (state == DUSC_SEEK) & seek_done;
   // lba position goes back into the parameter registers
   wire seek_wb = seek_end & seek_lba;
   wire bad_sense = is_sense & (feature != DUSC_SENSE_FEATURE);
   wire sense_ok = is_sense & (feature == DUSC_SENSE_FEATURE);
   wire unknown_op = ~is_unlock & ~is_seek & ~is_sense;
   wire early_abort = (is_unlock & pre_abort) | bad_sense | unknown_op;

   // each password word is compared; the verdict waits for the full sector
   assign cmp_bus.clear = wr_cmd;
   assign cmp_bus.load = wr_data & in_pw;
   assign cmp_bus.got = pwdata;
   // identifier picks which stored password to compare
   assign cmp_bus.want = ident_master ? want_master : want_user;

   // temperature: code = 2*(t+20), saturate at -20 and above 107
   wire [8:0] t_sum = {1'b0, temperature_deg} + 9'd20;
   wire t_low = temperature_negative & (temperature_deg >= 8'd20);
   wire [8:0] t_neg = 9'd20 - {1'b0, temperature_deg};
   wire t_high = ~temperature_negative & (temperature_deg > 8'd107);
   // readings past either end saturate instead of wrapping
   always_comb begin
      temp_code = 8'(t_sum << 1);
      if (temperature_negative) begin
         temp_code = 8'(t_neg << 1);
      end
      if (t_low) begin
         temp_code = DUSC_TEMP_SAT_LO;
      end else if (t_high) begin
         temp_code = DUSC_TEMP_SAT_HI;
      end
   end

   always_comb begin
      next_state = state;
      case (state)
         DUSC_IDLE: begin
            if (wr_cmd && is_unlock && !pre_abort) begin
               next_state = DUSC_XFER;
            end else if (wr_cmd && is_seek) begin
               next_state = DUSC_SEEK;
            end else if (wr_cmd) begin
               next_state = DUSC_DONE;
            end
         end
         DUSC_XFER: begin
            if (wr_data && last_word) begin
               next_state = DUSC_CHECK;
            end
         end
         // level and identifier refusals still take the whole sector
         DUSC_CHECK: begin
            next_state = DUSC_DONE;
         end
         DUSC_SEEK: begin
            if (seek_done) begin
               next_state = DUSC_DONE;
            end
         end
         DUSC_DONE: begin
            next_state = DUSC_IDLE;
         end
         default: begin
            next_state = DUSC_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= DUSC_IDLE;
      end else begin
         state <= next_state;
      end
   end

   assign busy = (state != DUSC_IDLE);
   assign drq = (state == DUSC_XFER);

   // parameter registers; the block writes back results
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         feature <= 8'h00;
         count <= 8'h00;
         secnum <= 8'h00;
         cyl_lo <= 8'h00;
         cyl_hi <= 8'h00;
         head <= DUSC_HEAD_RESET;
         cmd <= 8'h00;
      end else begin
         if (wr_param && sel_feature) feature <= pwdata[7:0];
         if (wr_param && sel_count) count <= pwdata[7:0];
         if (wr_param && sel_secnum) secnum <= pwdata[7:0];
         if (wr_param && sel_cyl_lo) cyl_lo <= pwdata[7:0];
         if (wr_param && sel_cyl_hi) cyl_hi <= pwdata[7:0];
         if (wr_param && sel_head) head <= pwdata[7:0];
         if (wr_cmd) cmd <= op;
         if (wr_cmd && sense_ok) begin
            count <= temp_code;
         end
         // bus writes are refused while busy, so these never clash
         if (seek_wb) begin
            secnum <= seek_target[7:0];
            cyl_lo <= seek_target[15:8];
            cyl_hi <= seek_target[23:16];
            head[3:0] <= seek_target[27:24];
         end
      end
   end

   // security state; reset relocks and enables security
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         locked <= 1'b1;
         attempts <= DUSC_ATTEMPTS_INIT;
         sec_en <= 1'b1;
         sec_max <= 1'b0;
      end else begin
         if (wr_param && sel_security) begin
            sec_en <= pwdata[DUSC_SEC_EN];
            sec_max <= pwdata[DUSC_SEC_MAX];
         end
         // a refused level or identifier costs no attempt
         if (check_cycle && !refuse_late) begin
            if (pw_bad) begin
               attempts <= attempts - 3'h1;
            end else begin
               locked <= 1'b0;
            end
         end
      end
   end

   // sector word counter and identifier capture
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         word_idx <= 8'h00;
         ident_master <= 1'b0;
      end else begin
         if (wr_cmd) begin
            word_idx <= 8'h00;
         end else if (wr_data) begin
            word_idx <= word_idx + 8'h01;
         end
         if (wr_data && word_idx == 8'h00) begin
            ident_master <= pwdata[0];
         end
      end
   end

   // seek runs regardless of format state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seek_cnt <= 8'h00;
         seek_target <= 28'h0;
         seek_lba <= 1'b0;
         seek_start <= 1'b0;
      end else begin
         seek_start <= wr_cmd & is_seek;
         if (wr_cmd && is_seek) begin
            seek_lba <= lba_mode;
            if (lba_mode) begin
               seek_target <= {head[3:0], cyl_hi, cyl_lo, secnum};
            end else begin
               seek_target <= {8'h00, head[3:0], cyl_hi, cyl_lo};
            end
         end
         if (state == DUSC_SEEK) begin
            seek_cnt <= seek_cnt + 8'h01;
         end else begin
            seek_cnt <= 8'h00;
         end
      end
   end

   // completion status; abort and error flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         error_flags <= 8'h00;
         err <= 1'b0;
         dsc <= 1'b0;
      end else if (wr_cmd) begin
         error_flags <= 8'h00;
         err <= 1'b0;
         dsc <= 1'b0;
         if (early_abort) begin
            error_flags[DUSC_ER_ABT] <= 1'b1;
            err <= 1'b1;
         end
      end else if (check_cycle) begin
         if (refuse_late || pw_bad) begin
            error_flags[DUSC_ER_ABT] <= 1'b1;
            err <= 1'b1;
         end
      end else if (seek_end) begin
         dsc <= 1'b1;
      end
   end

   // busy is hidden while the sector is being requested
   wire [7:0] status = {busy & ~drq, 1'b1, 1'b0, dsc, drq, 2'b00, err};
   wire [31:0] pos_word = {4'h0, seek_target};
   wire [7:0] sec_word = {5'h0, locked, sec_max, sec_en};
   wire [31:0] sec_rd = {21'h0, attempts, sec_word};
   wire [31:0] rd_mux =
      sel_feature ? {24'h0, feature} :
      sel_count ? {24'h0, count} :
      sel_secnum ? {24'h0, secnum} :
      sel_cyl_lo ? {24'h0, cyl_lo} :
      sel_cyl_hi ? {24'h0, cyl_hi} :
      sel_head ? {24'h0, head} :
      sel_cmd ? {24'h0, status} :
      sel_error ? {24'h0, error_flags} :
      sel_security ? sec_rd :
      sel_pos ? pos_word : 32'h0;
   // holes in the map answer with an error, never with a stall
   wire mapped = (paddr <= DUSC_A_POS) && (paddr[1:0] == 2'b00);
   wire rd_setup = psel & ~penable & ~pwrite;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (rd_setup) begin
         prdata <= rd_mux;
      end
   end

   // read data is latched in setup, so no wait state is ever needed
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped & (rd_unused | pwrite);
endmodule : dusc_top
`default_nettype wire

// >>> sim/dusc_asserts.sv
// Purpose: port checks on the seek outputs
// Assumes: seek parameters written before the command
// Notes: shadow bytes mirror parameter writes
`timescale 1ns/1ps
`default_nettype none
module dusc_asserts
   import dusc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [27:0] seek_target,
   input wire logic seek_lba,
   input wire logic seek_start
);
   logic [7:0] sn, cl, ch, hd;
   wire wr = psel && penable && pwrite;
   wire cmd = wr && paddr == DUSC_A_CMD;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   always_ff @(posedge pclk) begin
      if (wr && paddr == DUSC_A_SECNUM) sn <= pwdata[7:0];
      if (wr && paddr == DUSC_A_CYL_LO) cl <= pwdata[7:0];
      if (wr && paddr == DUSC_A_CYL_HI) ch <= pwdata[7:0];
      if (wr && paddr == DUSC_A_HEAD) hd <= pwdata[7:0];
   end
   seek_cause_a: assert property (seek_start |->
      $past(cmd && pwdata[7:4] == DUSC_OP_SEEK_HI)) else $error("stray seek");
   seek_pulse_a: assert property (seek_start |=> !seek_start)
      else $error("seek pulse too long");
   other_op_a: assert property (cmd && pwdata[7:4] != 4'h7 |=>
      !seek_start) else $error("seek on other opcode");
   lba_target_a: assert property (seek_start && hd[6] |->
      seek_target == {hd[3:0], ch, cl, sn}) else $error("lba target");
   chs_target_a: assert property (seek_start && !hd[6] |->
      seek_target == {8'h00, hd[3:0], ch, cl}) else $error("chs target");
   mode_flag_a: assert property (seek_start |-> seek_lba == hd[6])
      else $error("mode flag");
   target_hold_a: assert property (!seek_start |->
      $stable(seek_target)) else $error("target moved");
   mode_hold_a: assert property (!seek_start |-> $stable(seek_lba))
      else $error("mode moved");
endmodule : dusc_asserts
bind dusc_top dusc_asserts i_dusc_asserts (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .seek_target(seek_target), .seek_lba(seek_lba),
   .seek_start(seek_start));
`default_nettype wire

// >>> sim/dusc_host.sv
// Purpose: host controller model, apb master side
// Assumes: calls start just after a rising edge
// Notes: reserved sector words sent as ones, not zeros
`timescale 1ns/1ps
`default_nettype none
module dusc_host
   import dusc_pkg::*;
(
   input wire logic pclk,
   output logic psel = 1'b0,
   output logic penable = 1'b0,
   output logic pwrite = 1'b0,
   output logic [7:0] paddr = 8'h00,
   output logic [31:0] pwdata = 32'h0,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // moves just after a rising edge, samples the answer on one
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd, output logic er);
      logic ok;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         ok = pready;
         rd = prdata;
         er = pslverr;
      end while (ok !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : xfer
   task automatic unlock(input logic id, input logic [511:0] pw,
      input logic send);
      logic [31:0] d;
      logic e;
      xfer(1'b1, DUSC_A_CMD, {24'h0, DUSC_OP_UNLOCK}, d, e);
      if (send) begin
         xfer(1'b1, DUSC_A_DATA, {31'h0, id}, d, e);
         for (int k = 0; k < DUSC_SECTOR_WORDS - 1; k++) begin
            xfer(1'b1, DUSC_A_DATA,
               k < DUSC_PW_WORDS ? pw[32*k+:32] : 32'hffff_ffff, d, e);
         end
      end
   endtask : unlock
endmodule : dusc_host
`default_nettype wire

// >>> sim/tb.sv
// Purpose: self-checking bench for unlock, seek and sense
// Assumes: zero wait state slave
// Notes: seek time shortened to 4 cycles
`timescale 1ns/1ps
`default_nettype none
module tb
   import dusc_pkg::*;
   ;
   localparam logic [511:0] mpw = {16{32'h1357_9bdf}};
   localparam logic [511:0] upw = {16{32'h2468_ace0}};
   localparam logic [511:0] bad = upw ^ {32'h1, 480'h0};
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic seek_lba, seek_start, c_lba, tneg, e;
   logic [7:0] paddr, tdeg;
   logic [31:0] pwdata, prdata, d;
   logic [27:0] seek_target, c_tgt;
   int errors, n_tests, n_seek;
   dusc_top #(.SEEK_CYCLES(4)) i_dusc_top (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .master_password(mpw), .user_password(upw), .temperature_deg(tdeg),
      .temperature_negative(tneg), .seek_target(seek_target),
      .seek_lba(seek_lba), .seek_start(seek_start));
   dusc_host i_dusc_host (.pclk(pclk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   always @(negedge pclk) begin
      if (seek_start === 1'b1) begin
         n_seek <= n_seek + 1;
         c_tgt <= seek_target;
         c_lba <= seek_lba;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      i_dusc_host.xfer(1'b1, a, v, d, e);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      i_dusc_host.xfer(1'b0, a, 32'h0, d, e);
   endtask : rd
   task automatic rst;
      presetn <= 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
   endtask : rst
   // bounded poll of status; a stuck device counts as a mismatch
   task automatic wait_st(input logic [7:0] m, input logic [7:0] v);
      rd(DUSC_A_CMD);
      for (int n = 0; n < 100 && (d[7:0] & m) !== v; n++) rd(DUSC_A_CMD);
      chk({24'h0, d[7:0] & m}, {24'h0, v});
   endtask : wait_st
   // unlock with full sector, then error bit and masked security word
   task automatic unl(input logic id, input logic [511:0] pw,
      input logic ab, input logic [31:0] m, input logic [31:0] s);
      i_dusc_host.unlock(id, pw, 1'b1);
      repeat (3) @(posedge pclk);
      wait_st(8'h88, 8'h00);
      rd(DUSC_A_ERROR);
      chk(d & 32'h4, {29'h0, ab, 2'h0});
      rd(DUSC_A_SECURITY);
      chk(d & m, s);
   endtask : unl
   task automatic t_lock;
      rst;
      rd(DUSC_A_SECURITY);
      chk(d & 32'h707, 32'h505);
      rd(DUSC_A_HEAD);
      chk(d & 32'hff, {24'h0, DUSC_HEAD_RESET});
      unl(1'b0, bad, 1'b1, 32'h707, 32'h405);
      unl(1'b0, upw, 1'b0, 32'h7, 32'h1);
      rst;
      unl(1'b1, mpw, 1'b0, 32'h7, 32'h1);
      rst;
      wr(DUSC_A_SECURITY, 32'h3);
      unl(1'b1, mpw, 1'b1, 32'h707, 32'h507);
      wr(DUSC_A_SECURITY, 32'h0);
      unl(1'b0, upw, 1'b1, 32'h707, 32'h504);
      rd(8'h2c);
      chk({31'h0, e}, 32'h1);
   endtask : t_lock
   task automatic t_count;
      rst;
      repeat (5) unl(1'b0, bad, 1'b1, 32'h0, 32'h0);
      rd(DUSC_A_SECURITY);
      chk(d & 32'h700, 32'h0);
      i_dusc_host.unlock(1'b0, upw, 1'b0);
      wait_st(8'h89, 8'h01);
      rst;
      rd(DUSC_A_SECURITY);
      chk(d & 32'h700, 32'h500);
   endtask : t_count
   task automatic t_seek(input logic [7:0] h, input logic [3:0] lo,
      input logic [27:0] t);
      n_seek = 0;
      wr(DUSC_A_SECNUM, 32'h12);
      wr(DUSC_A_CYL_LO, 32'h34);
      wr(DUSC_A_CYL_HI, 32'h56);
      wr(DUSC_A_HEAD, {24'h0, h});
      wr(DUSC_A_CMD, {24'h0, DUSC_OP_SEEK_HI, lo});
      wait_st(8'h91, 8'h10);
      chk(32'(n_seek), 32'h1);
      chk({3'h0, c_lba, c_tgt}, {3'h0, h[6], t});
      rd(DUSC_A_POS);
      if (h[6]) chk({4'h0, d[27:0]}, {4'h0, t});
   endtask : t_seek
   task automatic t_sense;
      int tv[5] = '{25, -20, -19, 107, 108};
      foreach (tv[i]) begin
         tdeg <= 8'(tv[i] < 0 ? -tv[i] : tv[i]);
         tneg <= tv[i] < 0;
         wr(DUSC_A_FEATURE, 32'h1);
         wr(DUSC_A_CMD, {24'h0, DUSC_OP_SENSE});
         rd(DUSC_A_COUNT);
         chk(d & 32'hff, tv[i] <= -20 ? 32'h0 : tv[i] > 107 ? 32'hff :
            32'(2 * (tv[i] + 20)));
      end
      wr(DUSC_A_FEATURE, 32'h2);
      wr(DUSC_A_CMD, {24'h0, DUSC_OP_SENSE});
      rd(DUSC_A_ERROR);
      chk(d & 32'h4, 32'h4);
   endtask : t_sense
   task automatic summarize;
      $display("errors %0d tests %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : summarize
   initial begin
      presetn = 1'b0;
      tdeg = 8'h00;
      tneg = 1'b0;
      t_lock;
      t_count;
      t_seek(8'he7, 4'h0, 28'h7563412);
      t_seek(8'ha3, 4'hf, 28'h0035634);
      t_sense;
      summarize;
   end
   initial begin
      repeat (40000) @(posedge pclk);
      errors++;
      summarize;
   end
endmodule : tb
`default_nettype wire
